//--- verilog/bst_pkg.sv
package bst_pkg;
   // ==========================================================
   // tap states
   // ==========================================================
   typedef enum logic [3:0] {
      ST_RESET = 4'h0, ST_IDLE = 4'h1, ST_SEL_DR = 4'h2, ST_CAP_DR = 4'h3,
      ST_SH_DR = 4'h4, ST_EX1_DR = 4'h5, ST_PAU_DR = 4'h6, ST_EX2_DR = 4'h7,
      ST_UPD_DR = 4'h8, ST_SEL_IR = 4'h9, ST_CAP_IR = 4'ha, ST_SH_IR = 4'hb,
      ST_EX1_IR = 4'hc, ST_PAU_IR = 4'hd, ST_EX2_IR = 4'he, ST_UPD_IR = 4'hf
   } bst_state_e;

   // ==========================================================
   // instruction codes
   // ==========================================================
   localparam int IR_LEN = 4;
   localparam logic [3:0] OP_EXTEST = 4'h0;
   localparam logic [3:0] OP_IDCODE = 4'h1;
   localparam logic [3:0] OP_SAMPLE = 4'h5;
   localparam logic [3:0] OP_CLAMP = 4'h7;
   localparam logic [3:0] OP_BYPASS = 4'hf;
   localparam logic [3:0] IR_CAPTURE = 4'h1;

   typedef enum logic [2:0] {
      SEL_EXTEST = 3'h0, SEL_IDCODE = 3'h1, SEL_SAMPLE = 3'h2,
      SEL_CLAMP = 3'h3, SEL_BYPASS = 3'h4
   } bst_sel_e;

   // ==========================================================
   // identification fields (values arbitrary)
   // ==========================================================
   localparam int ID_LEN = 32;
   localparam int ID_VER_LSB = 28;
   localparam int ID_PART_LSB = 12;
   localparam int ID_MFR_LSB = 1;
   localparam logic [3:0] ID_VERSION = 4'h1;
   localparam logic [15:0] ID_PART = 16'h0a5c;
   localparam logic [10:0] ID_MFR = 11'h123;

   // ==========================================================
   // chain geometry
   // ==========================================================
   localparam int CHAIN_LEN = 299;
   localparam int CTL_CNT = 8;
   localparam int CTL_POS [CTL_CNT] = '{2, 5, 12, 40, 80, 130, 200, 290};

   typedef struct packed {
      logic tck;
      logic tms;
      logic tdi;
      logic trst_n;
   } bst_pins_s;
endpackage

//--- verilog/bst_sync3.sv
`timescale 1ns/1ns
module bst_sync3 (
   input wire logic clk_sys,
   input wire logic reset_n,
   input wire logic pin,
   output logic level,
   output logic rise,
   output logic fall
);
   logic s1_q, s2_q, s3_q;

   // change counts only once second and third stages agree
   always_ff @(posedge clk_sys) begin
      if (!reset_n) begin
         s1_q <= 1'b0;
         s2_q <= 1'b0;
         s3_q <= 1'b0;
         level <= 1'b0;
      end else begin
         s1_q <= pin;
         s2_q <= s1_q;
         s3_q <= s2_q;
         if (s2_q == s3_q) begin
            level <= s3_q;
         end
      end
   end

   assign rise = (s2_q == s3_q) && s3_q && !level;
   assign fall = (s2_q == s3_q) && !s3_q && level;
endmodule

//--- verilog/bst_tap.sv
`timescale 1ns/1ns
// What this block does
// - identification is 32 bits: version, part, maker, and one in bit 0.
// - the instruction register is four bits, shifted in serially.
// - 0000 extest, 0001 idcode, 0101 sample, 0111 clamp, 1111 bypass.
// - one 299-cell boundary chain sits between data in and data out.
// - a set control cell disables its outputs when the chain drives pins.
// - in test-logic-reset every control cell is preset to one.
// - data out and its enable change on the falling test clock edge.
// - mode select and data in are sampled on the rising test clock edge.
module bst_tap
   import bst_pkg::*;
(
   input wire logic clk_sys,
   input wire logic reset_n,
   input bst_pkg::bst_pins_s pins,
   input wire logic [bst_pkg::CHAIN_LEN-1:0] pin_in,
   input wire logic [bst_pkg::CHAIN_LEN-1:0] core_out,
   output logic tdo,
   output logic tdo_oe_n,
   output logic [bst_pkg::CHAIN_LEN-1:0] pin_out,
   output logic [bst_pkg::CTL_CNT-1:0] pin_oe_n,
   output logic scan_drive,
   output logic [3:0] instr
);
   import bst_pkg::*;

   // ==========================================================
   // pin sampling
   // ==========================================================
   logic tck_lvl, tck_rise, tck_fall;
   logic tms_lvl, tdi_lvl, trst_lvl;

   bst_sync3 u_tck (.clk_sys(clk_sys), .reset_n(reset_n), .pin(pins.tck),
      .level(tck_lvl), .rise(tck_rise), .fall(tck_fall));
   bst_sync3 u_tms (.clk_sys(clk_sys), .reset_n(reset_n), .pin(pins.tms),
      .level(tms_lvl), .rise(), .fall());
   bst_sync3 u_tdi (.clk_sys(clk_sys), .reset_n(reset_n), .pin(pins.tdi),
      .level(tdi_lvl), .rise(), .fall());
   bst_sync3 u_trst (.clk_sys(clk_sys), .reset_n(reset_n),
      .pin(pins.trst_n), .level(trst_lvl), .rise(), .fall());

   // trst stays low for three tck periods, far above the sync delay
   logic trst_hit;
   logic trst_seen_q;
   always_ff @(posedge clk_sys) begin
      if (!reset_n) begin
         trst_seen_q <= 1'b0;
      end else begin
         trst_seen_q <= 1'b1;
      end
   end
   assign trst_hit = trst_seen_q && !trst_lvl;

   // ==========================================================
   // tap controller
   // ==========================================================
   bst_state_e state_q, state_d;

   always_comb begin
      case (state_q)
         ST_RESET: state_d = tms_lvl ? ST_RESET : ST_IDLE;
         ST_IDLE: state_d = tms_lvl ? ST_SEL_DR : ST_IDLE;
         ST_SEL_DR: state_d = tms_lvl ? ST_SEL_IR : ST_CAP_DR;
         ST_CAP_DR: state_d = tms_lvl ? ST_EX1_DR : ST_SH_DR;
         ST_SH_DR: state_d = tms_lvl ? ST_EX1_DR : ST_SH_DR;
         ST_EX1_DR: state_d = tms_lvl ? ST_UPD_DR : ST_PAU_DR;
         ST_PAU_DR: state_d = tms_lvl ? ST_EX2_DR : ST_PAU_DR;
         ST_EX2_DR: state_d = tms_lvl ? ST_UPD_DR : ST_SH_DR;
         ST_UPD_DR: state_d = tms_lvl ? ST_SEL_DR : ST_IDLE;
         ST_SEL_IR: state_d = tms_lvl ? ST_RESET : ST_CAP_IR;
         ST_CAP_IR: state_d = tms_lvl ? ST_EX1_IR : ST_SH_IR;
         ST_SH_IR: state_d = tms_lvl ? ST_EX1_IR : ST_SH_IR;
         ST_EX1_IR: state_d = tms_lvl ? ST_UPD_IR : ST_PAU_IR;
         ST_PAU_IR: state_d = tms_lvl ? ST_EX2_IR : ST_PAU_IR;
         ST_EX2_IR: state_d = tms_lvl ? ST_UPD_IR : ST_SH_IR;
         ST_UPD_IR: state_d = tms_lvl ? ST_SEL_DR : ST_IDLE;
         default: state_d = ST_RESET;
      endcase
   end

   always_ff @(posedge clk_sys) begin
      if (!reset_n || trst_hit) begin
         state_q <= ST_RESET;
      end else if (tck_rise) begin
         state_q <= state_d;
      end
   end

   // ==========================================================
   // instruction register
   // ==========================================================
   logic [IR_LEN-1:0] ir_sh_q;
   bst_sel_e sel;

   always_ff @(posedge clk_sys) begin
      if (!reset_n || trst_hit) begin
         ir_sh_q <= IR_CAPTURE;
         instr <= OP_IDCODE;
      end else if (state_q == ST_RESET) begin
         instr <= OP_IDCODE;
      end else if (tck_rise) begin
         case (state_q)
            ST_CAP_IR: ir_sh_q <= IR_CAPTURE;
            ST_SH_IR: begin
               ir_sh_q <= {tdi_lvl, ir_sh_q[IR_LEN-1:1]};
            end
            default: ir_sh_q <= ir_sh_q;
         endcase
      end else if (tck_fall && state_q == ST_UPD_IR) begin
         instr <= ir_sh_q;
      end
   end

   always_comb begin
      case (instr)
         OP_EXTEST: sel = SEL_EXTEST;
         OP_IDCODE: sel = SEL_IDCODE;
         OP_SAMPLE: sel = SEL_SAMPLE;
         OP_CLAMP: sel = SEL_CLAMP;
         OP_BYPASS: sel = SEL_BYPASS;
         default: sel = SEL_BYPASS;
      endcase
   end

   // ==========================================================
   // data registers
   // ==========================================================
   logic [ID_LEN-1:0] id_q;
   logic byp_q;
   logic [CHAIN_LEN-1:0] bsr_q;
   logic [CHAIN_LEN-1:0] upd_q;
   logic [ID_LEN-1:0] id_word;
   logic [CHAIN_LEN-1:0] ctl_mask;

   assign id_word = {ID_VERSION, ID_PART, ID_MFR, 1'b1};

   always_comb begin
      ctl_mask = '0;
      for (int k = 0; k < CTL_CNT; k++) begin
         ctl_mask[CTL_POS[k]] = 1'b1;
      end
   end

   always_ff @(posedge clk_sys) begin
      if (!reset_n) begin
         id_q <= '0;
         byp_q <= 1'b0;
         bsr_q <= '0;
      end else if (tck_rise && state_q == ST_CAP_DR) begin
         id_q <= id_word;
         byp_q <= 1'b0;
         bsr_q <= (sel == SEL_EXTEST) ? core_out : pin_in;
      end else if (tck_rise && state_q == ST_SH_DR) begin
         case (sel)
            SEL_IDCODE: id_q <= {tdi_lvl, id_q[ID_LEN-1:1]};
            SEL_EXTEST, SEL_SAMPLE:
               bsr_q <= {tdi_lvl, bsr_q[CHAIN_LEN-1:1]};
            default: byp_q <= tdi_lvl;
         endcase
      end
   end

   // update stage; controls preset to one in reset state
   always_ff @(posedge clk_sys) begin
      if (!reset_n || trst_hit || state_q == ST_RESET) begin
         upd_q <= ctl_mask;
      end else if (tck_fall && state_q == ST_UPD_DR &&
                   (sel == SEL_EXTEST || sel == SEL_SAMPLE)) begin
         upd_q <= bsr_q;
      end
   end

   // ==========================================================
   // pin drive
   // ==========================================================
   logic drive;
   assign drive = (sel == SEL_EXTEST) || (sel == SEL_CLAMP);

   always_ff @(posedge clk_sys) begin
      if (!reset_n) begin
         pin_out <= '0;
         pin_oe_n <= '1;
         scan_drive <= 1'b0;
      end else begin
         scan_drive <= drive;
         pin_out <= drive ? upd_q : core_out;
         for (int k = 0; k < CTL_CNT; k++) begin
            pin_oe_n[k] <= drive ? upd_q[CTL_POS[k]]
                                 : core_out[CTL_POS[k]];
         end
      end
   end

   // ==========================================================
   // serial out, falling edge
   // ==========================================================
   logic tdo_d;
   always_comb begin
      if (state_q == ST_SH_IR) begin
         tdo_d = ir_sh_q[0];
      end else begin
         case (sel)
            SEL_IDCODE: tdo_d = id_q[0];
            SEL_EXTEST, SEL_SAMPLE: tdo_d = bsr_q[0];
            default: tdo_d = byp_q;
         endcase
      end
   end

   always_ff @(posedge clk_sys) begin
      if (!reset_n) begin
         tdo <= 1'b0;
         tdo_oe_n <= 1'b1;
      end else if (tck_fall) begin
         tdo <= tdo_d;
         tdo_oe_n <= !(state_q == ST_SH_DR || state_q == ST_SH_IR);
      end
   end

   // ==========================================================
   // checks
   // ==========================================================
   a_tdo_edge: assert property (
      @(posedge clk_sys) disable iff (!reset_n)
      $changed(tdo_oe_n) |-> $past(tck_fall))
      else $error("tdo enable moved off a falling tck");
   a_state_edge: assert property (
      @(posedge clk_sys) disable iff (!reset_n)
      (!$past(tck_rise) && !$past(trst_hit) && $past(reset_n))
      |-> $stable(state_q))
      else $error("tap state moved without tck rise");
   a_ctl_preset: assert property (
      @(posedge clk_sys) disable iff (!reset_n)
      state_q == ST_RESET |=> (upd_q & ctl_mask) == ctl_mask)
      else $error("control cells not preset");
   a_hiz_ctl: assert property (
      @(posedge clk_sys) disable iff (!reset_n)
      (drive && upd_q[CTL_POS[0]]) ##1 drive |-> pin_oe_n[0])
      else $error("control cell one did not disable output");
   a_byp_zero: assert property (
      @(posedge clk_sys) disable iff (!reset_n)
      tck_rise && state_q == ST_CAP_DR |=> !byp_q)
      else $error("bypass did not capture zero");
   a_id_cap: assert property (
      @(posedge clk_sys) disable iff (!reset_n)
      tck_rise && state_q == ST_CAP_DR
      |=> id_q == {ID_VERSION, ID_PART, ID_MFR, 1'b1})
      else $error("id capture wrong");
   a_ir_shift: assert property (
      @(posedge clk_sys) disable iff (!reset_n)
      tck_rise && state_q == ST_SH_IR && !trst_hit
      |=> ir_sh_q[IR_LEN-1] == $past(tdi_lvl))
      else $error("instruction shift wrong");
   a_unk_byp: assert property (
      @(posedge clk_sys) disable iff (!reset_n)
      instr == 4'h3 |-> sel == SEL_BYPASS)
      else $error("unknown code not bypass");
   a_chain_shift: assert property (
      @(posedge clk_sys) disable iff (!reset_n)
      tck_rise && state_q == ST_SH_DR && sel == SEL_SAMPLE
      |=> bsr_q[CHAIN_LEN-2] == $past(bsr_q[CHAIN_LEN-1]))
      else $error("chain shift wrong");
   a_dec_clamp: assert property (
      @(posedge clk_sys) disable iff (!reset_n)
      instr == OP_CLAMP |-> sel == SEL_CLAMP)
      else $error("clamp decode wrong");
   c_ir_upd: cover property (@(posedge clk_sys) state_q == ST_UPD_IR);
   c_extest: cover property (@(posedge clk_sys) scan_drive);
   c_dr_shift: cover property (@(posedge clk_sys)
      state_q == ST_SH_DR && sel == SEL_IDCODE);
endmodule

//--- verif/bst_tester.sv
`timescale 1ns/1ns
module bst_tester (
   input wire logic clk_sys,
   input wire logic tdo,
   input wire logic tdo_oe_n,
   output bst_pkg::bst_pins_s pins
);
   import bst_pkg::*;
   // ==========================================================
   // tester pins; tck stands still between transfers
   // ==========================================================
   initial pins = '{tck: 1'b0, tms: 1'b1, tdi: 1'b0, trst_n: 1'b1};

   task automatic half();
      repeat (8) @(posedge clk_sys);
      #1;
   endtask

   // a released tdo reads as unknown so a late enable is caught
   task automatic step(input logic tms, input logic tdi, output logic seen);
      pins.tms = tms;
      pins.tdi = tdi;
      half();
      seen = tdo_oe_n ? 1'bx : tdo;
      pins.tck = 1'b1;
      half();
      pins.tck = 1'b0;
   endtask

   // starts and ends in run-test/idle, lsb first
   task automatic shift(input logic ir, input logic [CHAIN_LEN-1:0] din,
         input int n, output logic [CHAIN_LEN-1:0] dout);
      logic b;
      dout = '0;
      step(1'b0, 1'b0, b);
      step(1'b1, 1'b0, b);
      if (ir) begin
         step(1'b1, 1'b0, b);
      end
      step(1'b0, 1'b0, b);
      step(1'b0, 1'b0, b);
      for (int i = 0; i < n; i++) begin
         step(i == n - 1, din[i], dout[i]);
      end
      step(1'b1, 1'b0, b);
      step(1'b0, 1'b0, b);
   endtask

   task automatic tlr();
      logic b;
      repeat (5) step(1'b1, 1'b0, b);
   endtask

   task automatic treset();
      pins.trst_n = 1'b0;
      repeat (6) half();
      pins.trst_n = 1'b1;
      repeat (2) half();
   endtask
endmodule

//--- verif/boundary_scan_tap_test.sv
`timescale 1ns/1ns
module boundary_scan_tap_test;
   import bst_pkg::*;
   logic clk_sys;
   logic reset_n;
   bst_pins_s pins;
   logic [CHAIN_LEN-1:0] pin_in, core_out, pin_out, d, pat;
   logic tdo, tdo_oe_n, scan_drive;
   logic [CTL_CNT-1:0] pin_oe_n, oe_x;
   logic [3:0] instr;
   int fail_count = 0;
   int total_checks = 0;

   bst_tap i_bst_tap (.clk_sys(clk_sys), .reset_n(reset_n), .pins(pins),
      .pin_in(pin_in), .core_out(core_out), .tdo(tdo),
      .tdo_oe_n(tdo_oe_n), .pin_out(pin_out), .pin_oe_n(pin_oe_n),
      .scan_drive(scan_drive), .instr(instr));
   bst_tester i_bst_tester (.clk_sys(clk_sys), .tdo(tdo),
      .tdo_oe_n(tdo_oe_n), .pins(pins));

   // ==========================================================
   // clock, watchdog, verdict
   // ==========================================================
   initial begin
      clk_sys = 1'b0;
      forever #2 clk_sys = ~clk_sys;
   end

   initial begin
      #250000;
      fail_count++;
      $display("[ERR] %0t watchdog expired", $time);
      print_verdict();
   end

   task automatic print_verdict();
      $display("checks %0d mismatches %0d", total_checks, fail_count);
      if (fail_count == 0 && total_checks > 0) begin
         $display("RESULT: PASS");
      end else begin
         $display("RESULT: FAIL");
      end
      $finish;
   endtask

   task automatic check(input logic [CHAIN_LEN-1:0] seen, exp,
         input string what);
      total_checks++;
      if (seen !== exp) begin
         fail_count++;
         $display("[ERR] %0t %s mismatch", $time, what);
      end
   endtask

   // ==========================================================
   // scenarios
   // ==========================================================
   task automatic load(input logic [3:0] op);
      logic [CHAIN_LEN-1:0] q;
      i_bst_tester.shift(1'b1, CHAIN_LEN'(op), 4, q);
      check(q[3:0], IR_CAPTURE, "ir capture");
      check(instr, op, "instruction");
   endtask

   task automatic t_reset();
      check(instr, OP_IDCODE, "reset instr");
      check(pin_oe_n, {CTL_CNT{1'b1}}, "reset oe");
      check(tdo_oe_n, 1'b1, "reset tdo oe");
      check(scan_drive, 1'b0, "reset drive");
      $display("reset test done");
   endtask

   task automatic t_idcode();
      i_bst_tester.shift(1'b0, '0, ID_LEN, d);
      check(d[31:0], {ID_VERSION, ID_PART, ID_MFR, 1'b1}, "id");
      check(tdo_oe_n, 1'b1, "idle tdo oe");
      $display("idcode test done");
   endtask

   task automatic t_codes();
      logic [3:0] ops [5] = '{OP_EXTEST, OP_IDCODE, OP_SAMPLE, OP_CLAMP,
         OP_BYPASS};
      foreach (ops[k]) load(ops[k]);
      $display("code test done");
   endtask

   task automatic t_bypass(input logic [3:0] op);
      load(op);
      i_bst_tester.shift(1'b0, pat, CHAIN_LEN, d);
      check(d, {pat[CHAIN_LEN-2:0], 1'b0}, "bypass");
      $display("bypass test done");
   endtask

   // mixed control cells; clamp must keep them, reset must preset them
   task automatic t_extest_clamp();
      load(OP_EXTEST);
      pat = '1;
      for (int k = 0; k < CTL_CNT; k++) begin
         pat[CTL_POS[k]] = k[0];
         oe_x[k] = k[0];
      end
      i_bst_tester.shift(1'b0, pat, CHAIN_LEN, d);
      check(d, core_out, "extest capture");
      check(pin_out, pat, "update cells");
      check(scan_drive, 1'b1, "extest drive");
      check(pin_oe_n, oe_x, "control cells");
      t_bypass(OP_CLAMP);
      check(pin_out, pat, "clamp cells");
      check(pin_oe_n, oe_x, "clamp control");
      i_bst_tester.tlr();
      check(instr, OP_IDCODE, "tlr instr");
      // preset cells only reach the pins once the chain drives them
      load(OP_CLAMP);
      check(pin_oe_n, {CTL_CNT{1'b1}}, "tlr preset");
      $display("extest test done");
   endtask

   task automatic t_sample();
      load(OP_SAMPLE);
      i_bst_tester.shift(1'b0, pat, CHAIN_LEN, d);
      check(d, pin_in, "sample capture");
      check(scan_drive, 1'b0, "sample drive");
      check(pin_out, core_out, "core path");
      $display("sample test done");
   endtask

   task automatic t_trst();
      load(OP_BYPASS);
      i_bst_tester.treset();
      check(instr, OP_IDCODE, "trst instr");
      load(OP_EXTEST);
      check(pin_oe_n, {CTL_CNT{1'b1}}, "trst preset");
      $display("trst test done");
   endtask

   initial begin
      reset_n = 1'b0;
      for (int i = 0; i < CHAIN_LEN; i++) begin
         pin_in[i] = (i % 5) < 2;
         core_out[i] = (i % 3) == 0;
      end
      repeat (12) @(posedge clk_sys);
      #1 reset_n = 1'b1;
      t_reset();
      t_idcode();
      t_codes();
      t_extest_clamp();
      t_sample();
      t_bypass(OP_BYPASS);
      t_bypass(4'h3);
      t_trst();
      print_verdict();
   end
endmodule
